// ===== include/fsop_defs.vh
// Constants for the fast lock and fractional output clock path
`ifndef FSOP_DEFS_VH
`define FSOP_DEFS_VH

// Clock and timing
`define FSOP_CLK_PERIOD_PS  5000
`define FSOP_MS_PS          1000000000
`define FSOP_MS_CYCLES      (`FSOP_MS_PS / `FSOP_CLK_PERIOD_PS)

// Fast lock option bit positions inside one four-bit group
`define FSOP_OPT_FSNAP      0
`define FSOP_OPT_PSNAP      1
`define FSOP_OPT_OLPULL     2
`define FSOP_OPT_WIDE       3
// Group positions inside the option select word
`define FSOP_GRP_ACQ_LSB    0
`define FSOP_GRP_REC_LSB    4

// Wide acquisition limit select bit positions
`define FSOP_WIDE_BW        0
`define FSOP_WIDE_PSL       1
`define FSOP_WIDE_DAMP      2

// Fractional divider layout
`define FSOP_INT_W          8
`define FSOP_FRAC_W         43
`define FSOP_DIV_W          51
`define FSOP_ACC_W          52
`define FSOP_ACC_ONE        52'h0080000000000

// Fine phase rate codes
`define FSOP_RATE_SLOW      2'h0
`define FSOP_RATE_MED       2'h1
`define FSOP_RATE_FAST      2'h2
// Divisor deviation per rate, in fraction units
`define FSOP_DEV_SLOW       52'h0000000100000
`define FSOP_DEV_MED        52'h0000001000000
`define FSOP_DEV_FAST       52'h0000010000000
// Picoseconds worked off per synthesizer tick per rate
`define FSOP_PS_SLOW        32'h00000001
`define FSOP_PS_MED         32'h00000004
`define FSOP_PS_FAST        32'h00000010

// Reset values
`define FSOP_RST_PS         32'h00000000
`define FSOP_RST_OFS        51'h0
`define FSOP_RST_DIV        32'h00000000

`endif

// ===== logic/fsop_synth.v
// Steerable fractional synthesizer with fine phase stepping
`timescale 1ns/10ps
`include "fsop_defs.vh"

module fsop_synth
(
   // Clock and reset
   input  wire                          clk,
   input  wire                          rst_n,
   // Divide ratio
   input  wire [`FSOP_INT_W-1:0]        div_int,
   input  wire [`FSOP_FRAC_W-1:0]       div_frac,
   input  wire signed [`FSOP_DIV_W-1:0] freq_ofs,
   // Fine phase
   input  wire signed [31:0]            fine_ps,
   input  wire [1:0]                    fine_rate,
   input  wire                          fine_step,
   // Outputs
   output reg                           tick_q,
   output wire                          fine_busy
);

   ////////////////////////////////////////////////////////////////////////
   // Rate decoding
   function [`FSOP_ACC_W-1:0] rate_dev;
      input [1:0] r;
      begin
         case (r)
            `FSOP_RATE_SLOW: rate_dev = `FSOP_DEV_SLOW;
            `FSOP_RATE_FAST: rate_dev = `FSOP_DEV_FAST;
            default:         rate_dev = `FSOP_DEV_MED;
         endcase
      end
   endfunction

   function [31:0] rate_ps;
      input [1:0] r;
      begin
         case (r)
            `FSOP_RATE_SLOW: rate_ps = `FSOP_PS_SLOW;
            `FSOP_RATE_FAST: rate_ps = `FSOP_PS_FAST;
            default:         rate_ps = `FSOP_PS_MED;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   reg  signed [31:0]            pend_q;
   reg  [`FSOP_ACC_W-1:0]        acc_q;
   wire [`FSOP_ACC_W-1:0]        base;
   wire [`FSOP_ACC_W-1:0]        ofs_ext;
   wire [`FSOP_ACC_W-1:0]        dev;
   wire [`FSOP_ACC_W-1:0]        d_eff;
   wire [`FSOP_ACC_W-1:0]        acc_n;
   wire [31:0]                   step_ps;
   wire [31:0]                   pend_mag;

   // Divisor = INT + FRAC/2^43 plus snap offset and fine deviation
   assign base    = {1'b0, div_int, div_frac};
   assign ofs_ext = {freq_ofs[`FSOP_DIV_W-1], freq_ofs};
   // Negative pending advances edges: smaller divisor, higher frequency
   assign dev     = (pend_q == 32'sh0) ? {`FSOP_ACC_W{1'b0}} :
                    pend_q[31] ? (~rate_dev(fine_rate) + 52'h1) :
                    rate_dev(fine_rate);
   assign d_eff   = base + ofs_ext + dev;
   assign acc_n   = acc_q + `FSOP_ACC_ONE;
   assign step_ps  = rate_ps(fine_rate);
   assign pend_mag = pend_q[31] ? (~pend_q + 32'h1) : pend_q;
   assign fine_busy = (pend_q != 32'sh0);

   // Phase accumulator, one input cycle per system clock
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         acc_q  <= {`FSOP_ACC_W{1'b0}};
         tick_q <= 1'b0;
      end
      else if (acc_n >= d_eff)
      begin
         acc_q  <= acc_n - d_eff;
         tick_q <= 1'b1;
      end
      else
      begin
         acc_q  <= acc_n;
         tick_q <= 1'b0;
      end
   end

   // Pending phase; new steps add onto what is left, no total limit
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pend_q <= `FSOP_RST_PS;
      else if (fine_step)
         pend_q <= pend_q + fine_ps;
      else if (tick_q && fine_busy)
      begin
         if (pend_mag <= step_ps)
            pend_q <= `FSOP_RST_PS;
         else if (pend_q[31])
            pend_q <= pend_q + $signed(step_ps);
         else
            pend_q <= pend_q - $signed(step_ps);
      end
   end

endmodule // fsop_synth

// ===== logic/fsop_outdiv.v
// Integer output divider with period-boundary reload
`timescale 1ns/10ps
`include "fsop_defs.vh"

module fsop_outdiv
(
   // Clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // Synthesizer tick and ratio
   input  wire        tick,
   input  wire [31:0] div,
   // Divided clock
   output reg         out_q
);

   ////////////////////////////////////////////////////////////////////////
   reg  [31:0] cnt_q;
   reg  [31:0] div_q;
   wire        wrap;
   wire [31:0] cnt_n;
   wire [31:0] div_n;
   wire [31:0] high_n;

   // Ratio only reloads at wrap, so no runt pulse on a change
   assign wrap   = (div_q == 32'h0) || (cnt_q >= div_q - 32'h1);
   assign cnt_n  = wrap ? 32'h0 : (cnt_q + 32'h1);
   assign div_n  = wrap ? div : div_q;
   // High for the ceiling half: exact 50/50 on even ratios
   assign high_n = div_n - {1'b0, div_n[31:1]};

   // Count synthesizer edges
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q <= 32'h0;
         div_q <= `FSOP_RST_DIV;
         out_q <= 1'b0;
      end
      else if (tick)
      begin
         cnt_q <= cnt_n;
         div_q <= div_n;
         out_q <= (div_n != 32'h0) && (cnt_n < high_n);
      end
   end

endmodule // fsop_outdiv

// ===== logic/fsop_top.v
// Fast lock sequencer, synthesizer bank and output dividers
`timescale 1ns/10ps
`include "fsop_defs.vh"

module fsop_top
#(
   parameter MS_CYCLES = `FSOP_MS_CYCLES
)
(
   // Clock and reset
   input  wire                         SYS_CLK,
   input  wire                         ARST_N,
   // Loop state and measurements
   input  wire                         LOCK_ACQUIRE_STATE,
   input  wire                         LOCK_RECOVER_STATE,
   input  wire                         LOCK_DETECT,
   input  wire                         PULLIN_DONE,
   input  wire                         MEAS_VALID,
   input  wire signed [`FSOP_DIV_W-1:0] MEAS_FREQ_OFS,
   input  wire [47:0]                  MEAS_PHASE_OFS,
   // Fast lock configuration
   input  wire [7:0]                   FASTLOCK_OPTION_SELECT,
   input  wire                         SNAP_SLOPE_LIMIT,
   input  wire [31:0]                  SNAP_SLOPE_VALUE,
   input  wire [2:0]                   WIDE_ACQ_LIMIT_SELECT,
   input  wire [31:0]                  ACQ_PHASE_SLOPE_VALUE,
   input  wire [15:0]                  ACQ_BANDWIDTH_VALUE,
   input  wire                         PREACQ_EN,
   input  wire [15:0]                  PREACQ_MS,
   // Synthesizer configuration
   input  wire [63:0]                  SYNTH_INT,
   input  wire [343:0]                 SYNTH_FRAC,
   input  wire [255:0]                 FINE_PHASE,
   input  wire [15:0]                  FINE_RATE,
   input  wire [7:0]                   FINE_STEP,
   // Output stage configuration
   input  wire                         STAGE4_SYNTH_SELECT,
   input  wire                         STAGE7_SYNTH_SELECT,
   input  wire [383:0]                 OUT_DIV,
   // Loop control outputs
   output wire                         LOOP_OPEN,
   output reg                          PHASE_SNAP_LOAD,
   output reg  [47:0]                  PHASE_SNAP_VALUE,
   output wire                         BW_MAX,
   output wire                         BW_RELAX,
   output wire                         PSL_RELAX,
   output wire                         DAMP_RELAX,
   output reg  [15:0]                  RELAX_BW_VALUE,
   output reg  [31:0]                  RELAX_PSL_VALUE,
   // Status
   output wire                         FASTLOCK_BUSY,
   output reg  [2:0]                   FASTLOCK_STEP,
   output reg  [`FSOP_DIV_W-1:0]       SNAP_APPLIED_OFS,
   output wire [7:0]                   FINE_BUSY,
   // Clocks
   output wire [7:0]                   SYNTH_FB_TICK,
   output wire [11:0]                  CLK_OUT
);

   ////////////////////////////////////////////////////////////////////////
   // Sequencer states
   localparam [2:0] ST_IDLE   = 3'h0;
   localparam [2:0] ST_FSNAP  = 3'h1;
   localparam [2:0] ST_FRAMP  = 3'h2;
   localparam [2:0] ST_PSNAP  = 3'h3;
   localparam [2:0] ST_OLPULL = 3'h4;
   localparam [2:0] ST_PREACQ = 3'h5;
   localparam [2:0] ST_WIDE   = 3'h6;
   localparam [2:0] ST_DONE   = 3'h7;

   // Next enabled option strictly after the given state
   // en: {wide, preacq, olpull, psnap, fsnap}
   function [2:0] next_opt;
      input [2:0] from;
      input [4:0] en;
      begin
         if (from < ST_FSNAP && en[0])
            next_opt = ST_FSNAP;
         else if (from < ST_PSNAP && en[1])
            next_opt = ST_PSNAP;
         else if (from < ST_OLPULL && en[2])
            next_opt = ST_OLPULL;
         else if (from < ST_PREACQ && en[3])
            next_opt = ST_PREACQ;
         else if (from < ST_WIDE && en[4])
            next_opt = ST_WIDE;
         else
            next_opt = ST_DONE;
      end
   endfunction

   // Synthesizer feeding each output path
   function [2:0] path_src;
      input integer p;
      input         s4;
      input         s7;
      begin
         if (p < 8)
            path_src = p[3:1];
         else if (p == 8)
            path_src = s4 ? 3'h5 : 3'h4;
         else if (p == 9)
            path_src = 3'h5;
         else if (p == 10)
            path_src = 3'h6;
         else
            path_src = s7 ? 3'h7 : 3'h6;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Option enables for the current loop state
   reg  [2:0]                   st_q;
   reg  [2:0]                   st_d;
   reg  [15:0]                  ms_left_q;
   reg  [31:0]                  ms_cnt_q;
   reg  signed [`FSOP_DIV_W-1:0] target_q;
   wire                         in_acq;
   wire                         in_state;
   wire [3:0]                   grp;
   wire [4:0]                   en;
   wire                         ms_tick;
   wire signed [`FSOP_DIV_W-1:0] applied;
   wire signed [`FSOP_DIV_W-1:0] gap;
   wire signed [`FSOP_DIV_W-1:0] slope;
   wire                         ramp_last;

   assign in_acq   = LOCK_ACQUIRE_STATE;
   assign in_state = LOCK_ACQUIRE_STATE | LOCK_RECOVER_STATE;
   // Separate enable group per loop state
   assign grp = in_acq ?
                FASTLOCK_OPTION_SELECT[`FSOP_GRP_ACQ_LSB +: 4] :
                FASTLOCK_OPTION_SELECT[`FSOP_GRP_REC_LSB +: 4];
   // Pull-in is skipped when phase snap also set; snap has precedence
   assign en = {grp[`FSOP_OPT_WIDE],
                in_acq & PREACQ_EN,
                grp[`FSOP_OPT_OLPULL] & ~grp[`FSOP_OPT_PSNAP],
                grp[`FSOP_OPT_PSNAP],
                grp[`FSOP_OPT_FSNAP]};

   assign applied   = SNAP_APPLIED_OFS;
   assign gap       = target_q - applied;
   assign slope     = {{(`FSOP_DIV_W-32){1'b0}}, SNAP_SLOPE_VALUE};
   assign ramp_last = (gap[`FSOP_DIV_W-1] ? -gap : gap) <= slope;

   ////////////////////////////////////////////////////////////////////////
   // Sequencer next state, walking options in fixed order
   always @*
   begin
      st_d = st_q;
      case (st_q)
         ST_IDLE:
            if (in_state)
               st_d = next_opt(ST_IDLE, en);
         ST_FSNAP:
            if (MEAS_VALID)
               st_d = SNAP_SLOPE_LIMIT ? ST_FRAMP :
                      next_opt(ST_FSNAP, en);
         ST_FRAMP:
            if (ramp_last)
               st_d = next_opt(ST_FRAMP, en);
         ST_PSNAP:
            if (MEAS_VALID)
               st_d = next_opt(ST_PSNAP, en);
         ST_OLPULL:
            if (PULLIN_DONE)
               st_d = next_opt(ST_OLPULL, en);
         ST_PREACQ:
            if (ms_left_q == 16'h0)
               st_d = next_opt(ST_PREACQ, en);
         ST_WIDE:
            if (LOCK_DETECT)
               st_d = ST_DONE;
         ST_DONE:
            st_d = ST_DONE;
         default:
            st_d = ST_IDLE;
      endcase
      // Leaving both lock states ends and rearms the sequence
      if (!in_state)
         st_d = ST_IDLE;
   end

   // Sequencer state register
   always @(posedge SYS_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         st_q <= ST_IDLE;
      else
         st_q <= st_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // Millisecond enable and pre-acquisition countdown
   assign ms_tick = (ms_cnt_q == MS_CYCLES - 1);

   always @(posedge SYS_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         ms_cnt_q  <= 32'h0;
         ms_left_q <= 16'h0;
      end
      else if (st_q != ST_PREACQ)
      begin
         ms_cnt_q  <= 32'h0;
         ms_left_q <= PREACQ_MS;
      end
      else if (ms_tick)
      begin
         ms_cnt_q  <= 32'h0;
         ms_left_q <= ms_left_q - 16'h1;
      end
      else
         ms_cnt_q <= ms_cnt_q + 32'h1;
   end

   ////////////////////////////////////////////////////////////////////////
   // Frequency snap: offset held until the next frequency snap
   always @(posedge SYS_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         target_q         <= `FSOP_RST_OFS;
         SNAP_APPLIED_OFS <= `FSOP_RST_OFS;
      end
      else if (st_q == ST_FSNAP && MEAS_VALID)
      begin
         // Measured against the loop's present frequency
         target_q <= applied + MEAS_FREQ_OFS;
         if (!SNAP_SLOPE_LIMIT)
            SNAP_APPLIED_OFS <= applied + MEAS_FREQ_OFS;
      end
      else if (st_q == ST_FRAMP)
      begin
         // Bounded step per cycle softens the output jump
         if (ramp_last)
            SNAP_APPLIED_OFS <= target_q;
         else if (gap[`FSOP_DIV_W-1])
            SNAP_APPLIED_OFS <= applied - slope;
         else
            SNAP_APPLIED_OFS <= applied + slope;
      end
   end

   // Phase snap load pulse and value
   always @(posedge SYS_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         PHASE_SNAP_LOAD  <= 1'b0;
         PHASE_SNAP_VALUE <= 48'h0;
      end
      else
      begin
         PHASE_SNAP_LOAD <= (st_q == ST_PSNAP) && MEAS_VALID && in_state;
         if (st_q == ST_PSNAP && MEAS_VALID)
            PHASE_SNAP_VALUE <= MEAS_PHASE_OFS;
      end
   end

   // Relaxed limit values latched as a sequence starts
   always @(posedge SYS_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         RELAX_BW_VALUE  <= 16'h0;
         RELAX_PSL_VALUE <= 32'h0;
         FASTLOCK_STEP   <= ST_IDLE;
      end
      else
      begin
         FASTLOCK_STEP <= st_d;
         if (st_q == ST_IDLE)
         begin
            RELAX_BW_VALUE  <= ACQ_BANDWIDTH_VALUE;
            RELAX_PSL_VALUE <= ACQ_PHASE_SLOPE_VALUE;
         end
      end
   end

   // Loop control levels; normal limits return once state leaves
   assign LOOP_OPEN  = (st_q == ST_OLPULL);
   assign BW_MAX     = (st_q == ST_PREACQ);
   assign BW_RELAX   = (st_q == ST_WIDE) &
                       WIDE_ACQ_LIMIT_SELECT[`FSOP_WIDE_BW];
   // Temporary slope cap also holds through pre-acquisition
   assign PSL_RELAX  = (st_q == ST_WIDE || st_q == ST_PREACQ) &
                       WIDE_ACQ_LIMIT_SELECT[`FSOP_WIDE_PSL];
   assign DAMP_RELAX = (st_q == ST_WIDE) &
                       WIDE_ACQ_LIMIT_SELECT[`FSOP_WIDE_DAMP];
   assign FASTLOCK_BUSY = (st_q != ST_IDLE) && (st_q != ST_DONE);

   ////////////////////////////////////////////////////////////////////////
   // Synthesizer bank; synthesizer 0 is steered by the loop
   wire [7:0] synth_tick;

   genvar s;
   generate
      for (s = 0; s < 8; s = s + 1)
      begin : g_synth
         fsop_synth u_synth
         (
            .clk       (SYS_CLK),
            .rst_n     (ARST_N),
            .div_int   (SYNTH_INT[s*`FSOP_INT_W +: `FSOP_INT_W]),
            .div_frac  (SYNTH_FRAC[s*`FSOP_FRAC_W +: `FSOP_FRAC_W]),
            .freq_ofs  ((s == 0) ? applied : `FSOP_RST_OFS),
            .fine_ps   (FINE_PHASE[s*32 +: 32]),
            .fine_rate (FINE_RATE[s*2 +: 2]),
            .fine_step (FINE_STEP[s]),
            .tick_q    (synth_tick[s]),
            .fine_busy (FINE_BUSY[s])
         );
      end
   endgenerate

   // Same tick goes to the feedback dividers
   assign SYNTH_FB_TICK = synth_tick;

   ////////////////////////////////////////////////////////////////////////
   // Output paths: 0-7 are the dual stage pairs, 8-11 single stages
   genvar p;
   generate
      for (p = 0; p < 12; p = p + 1)
      begin : g_path
         wire path_tick;
         // Both halves of a dual stage share one source
         assign path_tick = synth_tick[path_src(p, STAGE4_SYNTH_SELECT,
                                        STAGE7_SYNTH_SELECT)];
         fsop_outdiv u_div
         (
            .clk   (SYS_CLK),
            .rst_n (ARST_N),
            .tick  (path_tick),
            .div   (OUT_DIV[p*32 +: 32]),
            .out_q (CLK_OUT[p])
         );
      end
   endgenerate

endmodule // fsop_top

// ===== verification/fsop_assertions.sv
// Port-level checker for the fast lock and output clock path
`timescale 1ns/10ps
module fsop_assertions
(
   // Clock and reset
   input wire               SYS_CLK,
   input wire               ARST_N,
   // Inputs watched
   input wire               MEAS_VALID,
   input wire signed [50:0] MEAS_FREQ_OFS,
   input wire [47:0]        MEAS_PHASE_OFS,
   input wire               SNAP_SLOPE_LIMIT,
   input wire [2:0]         WIDE_ACQ_LIMIT_SELECT,
   input wire               STAGE4_SYNTH_SELECT,
   // Outputs watched
   input wire               LOOP_OPEN,
   input wire               PHASE_SNAP_LOAD,
   input wire [47:0]        PHASE_SNAP_VALUE,
   input wire               BW_MAX,
   input wire               BW_RELAX,
   input wire               PSL_RELAX,
   input wire               DAMP_RELAX,
   input wire               FASTLOCK_BUSY,
   input wire [2:0]         FASTLOCK_STEP,
   input wire [50:0]        SNAP_APPLIED_OFS,
   input wire [7:0]         SYNTH_FB_TICK,
   input wire [11:0]        CLK_OUT
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!ARST_N);
   ////////////////////////////////////////////////////////////////////////
   // Loop control outputs
   property p_open; LOOP_OPEN |-> FASTLOCK_BUSY && !BW_MAX; endproperty
   a_open: assert property (p_open)
      else $error("loop open outside pull-in");
   property p_max;
      BW_MAX |-> !BW_RELAX && !DAMP_RELAX
         && PSL_RELAX == WIDE_ACQ_LIMIT_SELECT[1];
   endproperty
   a_max: assert property (p_max)
      else $error("pre-acquisition outputs wrong");
   property p_relax;
      BW_RELAX || DAMP_RELAX |-> FASTLOCK_BUSY && !LOOP_OPEN
         && BW_RELAX == WIDE_ACQ_LIMIT_SELECT[0]
         && DAMP_RELAX == WIDE_ACQ_LIMIT_SELECT[2];
   endproperty
   a_relax: assert property (p_relax)
      else $error("relaxed limits do not follow selection");
   // Steps only move forward until the sequence returns to idle
   property p_order;
      FASTLOCK_STEP != 3'h0 && $past(FASTLOCK_STEP) != 3'h0
         |-> FASTLOCK_STEP >= $past(FASTLOCK_STEP);
   endproperty
   a_order: assert property (p_order)
      else $error("fast lock step went backwards");
   property p_snapval;
      PHASE_SNAP_LOAD |-> PHASE_SNAP_VALUE == $past(MEAS_PHASE_OFS);
   endproperty
   a_snapval: assert property (p_snapval)
      else $error("phase snap value not the measurement");
   property p_pulse; PHASE_SNAP_LOAD |=> !PHASE_SNAP_LOAD; endproperty
   a_pulse: assert property (p_pulse)
      else $error("phase snap load longer than one cycle");
   property p_fsnap;
      FASTLOCK_STEP == 3'h1 && MEAS_VALID && !SNAP_SLOPE_LIMIT
         |=> SNAP_APPLIED_OFS == $past(SNAP_APPLIED_OFS)
            + $past(MEAS_FREQ_OFS);
   endproperty
   a_fsnap: assert property (p_fsnap)
      else $error("frequency snap offset not applied in one step");
   ////////////////////////////////////////////////////////////////////////
   // Output clocks move only on their source synthesizer tick
   property p_tick;
      $changed(CLK_OUT[0]) |-> $past(SYNTH_FB_TICK[0]);
   endproperty
   a_tick: assert property (p_tick)
      else $error("stage 0 output moved without a tick");
   property p_stage4;
      $changed(CLK_OUT[8]) |-> ($past(STAGE4_SYNTH_SELECT) ?
         $past(SYNTH_FB_TICK[5]) : $past(SYNTH_FB_TICK[4]));
   endproperty
   a_stage4: assert property (p_stage4)
      else $error("stage 4 output not from selected source");
endmodule // fsop_assertions

bind fsop_top fsop_assertions i_chk (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
   .MEAS_VALID(MEAS_VALID), .MEAS_FREQ_OFS(MEAS_FREQ_OFS),
   .MEAS_PHASE_OFS(MEAS_PHASE_OFS), .SNAP_SLOPE_LIMIT(SNAP_SLOPE_LIMIT),
   .WIDE_ACQ_LIMIT_SELECT(WIDE_ACQ_LIMIT_SELECT), .LOOP_OPEN(LOOP_OPEN),
   .STAGE4_SYNTH_SELECT(STAGE4_SYNTH_SELECT), .BW_MAX(BW_MAX),
   .PHASE_SNAP_LOAD(PHASE_SNAP_LOAD), .PHASE_SNAP_VALUE(PHASE_SNAP_VALUE),
   .BW_RELAX(BW_RELAX), .PSL_RELAX(PSL_RELAX), .DAMP_RELAX(DAMP_RELAX),
   .FASTLOCK_BUSY(FASTLOCK_BUSY), .FASTLOCK_STEP(FASTLOCK_STEP),
   .SNAP_APPLIED_OFS(SNAP_APPLIED_OFS), .SYNTH_FB_TICK(SYNTH_FB_TICK),
   .CLK_OUT(CLK_OUT));

// ===== verification/fsop_rx.sv
// Downstream receiver model timing one output clock
`timescale 1ns/10ps
module fsop_rx
(
   // Sampling clock and observed clock
   input wire clk,
   input wire clk_in
);
   integer edges = 0;
   integer min_hi = 99999;
   integer min_lo = 99999;
   integer max_hi = 0;
   integer run = 0;
   reg     last = 1'b0;

   // Run before the first rising edge is partial, so it is not timed
   always @(posedge clk)
   begin
      if (clk_in === last)
         run = run + 1;
      else
      begin
         if (edges > 0 && last === 1'b1)
         begin
            min_hi = (run < min_hi) ? run : min_hi;
            max_hi = (run > max_hi) ? run : max_hi;
         end
         if (edges > 0 && last === 1'b0)
            min_lo = (run < min_lo) ? run : min_lo;
         if (clk_in === 1'b1)
            edges = edges + 1;
         last = clk_in;
         run = 1;
      end
   end
endmodule // fsop_rx

// ===== verification/fsop_top_bench.sv
// Self-checking bench for the fast lock and output clock path
`timescale 1ns/10ps
module fsop_top_bench;
   reg               clk = 1'b0, rst_n = 1'b0, acq = 1'b0, rec = 1'b0;
   reg               slope_en = 1'b0, pre_en = 1'b1, s4 = 1'b0, s7 = 1'b0;
   reg               lock_det = 1'b1, pull_done = 1'b1, mval = 1'b1;
   reg [2:0]         wsel = 3'h7;
   wire [15:0]       rbw;
   wire [31:0]       rpsl;
   reg signed [50:0] meas_f = 51'h0;
   reg [47:0]        meas_p = 48'h00000000A5A5;
   reg [7:0]         opt = 8'h00, fstep = 8'h00;
   reg [15:0]        frate = 16'h0000;
   reg [63:0]        sint = {8{8'h0E}};
   reg [343:0]       sfrac = 344'h1 << 85;
   reg [383:0]       odiv = {12{32'h00000004}};
   wire [2:0]        step;
   wire [50:0]       applied;
   wire [7:0]        fbusy, tick;
   wire [11:0]       cko;
   integer           error_cnt = 0, check_count = 0, i, n, m, prev;

   fsop_top #(.MS_CYCLES(4)) i_dut (.SYS_CLK(clk), .ARST_N(rst_n),
      .LOCK_ACQUIRE_STATE(acq), .LOCK_RECOVER_STATE(rec),
      .LOCK_DETECT(lock_det), .PULLIN_DONE(pull_done), .MEAS_VALID(mval),
      .MEAS_FREQ_OFS(meas_f), .MEAS_PHASE_OFS(meas_p),
      .FASTLOCK_OPTION_SELECT(opt), .SNAP_SLOPE_LIMIT(slope_en),
      .SNAP_SLOPE_VALUE(32'h00000002), .WIDE_ACQ_LIMIT_SELECT(wsel),
      .ACQ_PHASE_SLOPE_VALUE(32'h00000010), .ACQ_BANDWIDTH_VALUE(16'h0100),
      .PREACQ_EN(pre_en), .PREACQ_MS(16'h0001), .SYNTH_INT(sint),
      .SYNTH_FRAC(sfrac), .FINE_PHASE({8{32'h00000020}}), .FINE_RATE(frate),
      .FINE_STEP(fstep), .STAGE4_SYNTH_SELECT(s4), .STAGE7_SYNTH_SELECT(s7),
      .OUT_DIV(odiv), .LOOP_OPEN(), .PHASE_SNAP_LOAD(),
      .PHASE_SNAP_VALUE(), .BW_MAX(), .BW_RELAX(), .PSL_RELAX(),
      .DAMP_RELAX(), .RELAX_BW_VALUE(rbw), .RELAX_PSL_VALUE(rpsl),
      .FASTLOCK_BUSY(), .FASTLOCK_STEP(step), .SNAP_APPLIED_OFS(applied),
      .FINE_BUSY(fbusy), .SYNTH_FB_TICK(tick), .CLK_OUT(cko));
   fsop_rx r0 (.clk(clk), .clk_in(cko[0]));
   fsop_rx r1 (.clk(clk), .clk_in(cko[1]));

   always #2.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   task chk(input [63:0] got, input [63:0] exp);
   begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
         error_cnt = error_cnt + 1;
         $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   end
   endtask
   // Steps seen are packed three bits each, oldest first
   task run_lock(input [7:0] sel, input a, input [23:0] exp);
      reg [23:0] seq;
      reg [2:0]  last;
   begin
      seq = 24'h0;
      last = 3'h0;
      opt = sel;
      acq = a;
      rec = ~a;
      for (i = 0; i < 100 && last != 3'h7; i = i + 1)
      begin
         @(posedge clk);
         #1;
         if (step !== last)
         begin
            last = step;
            seq = {seq[20:0], last};
         end
      end
      chk(seq, exp);
      acq = 1'b0;
      rec = 1'b0;
      meas_p = meas_p + 48'h1;
      repeat (2) @(posedge clk);
      #1;
   end
   endtask
   task final_report;
   begin
      if (error_cnt == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence; ratios near 14 keep synthesizers in range
   initial
   begin
      repeat (5) @(posedge clk);
      #1 rst_n = 1'b1;
      n = 0;
      m = 0;
      repeat (1160)
      begin
         @(posedge clk);
         #1;
         n = n + tick[0];
         m = m + tick[1];
      end
      chk(n >= 82 && n <= 83, 1);
      chk(m >= 79 && m <= 81, 1);
      chk(r0.min_hi, 28);
      chk(r0.min_lo, 28);
      odiv[63:0] = {2{32'h00000006}};
      s4 = 1'b1;
      s7 = 1'b1;
      repeat (600) @(posedge clk);
      #1;
      chk(r0.min_hi, 28);
      chk(r0.max_hi, 42);
      chk(r0.edges, r1.edges);
      // Fine steps on an idle loop, slowest rate must take longest
      prev = 0;
      for (m = 2; m >= 0; m = m - 1)
      begin
         frate[1:0] = m[1:0];
         fstep[0] = 1'b1;
         @(posedge clk);
         #1 fstep[0] = 1'b0;
         for (n = 0; fbusy[0] === 1'b1 && n < 5000; n = n + 1)
         begin
            @(posedge clk);
            #1;
         end
         chk(n > prev, 1);
         prev = n;
      end
      meas_f = 51'sd5;
      run_lock(8'h01, 1'b1, 24'o157);
      chk(applied, 51'd5);
      slope_en = 1'b1;
      meas_f = 51'sd7;
      run_lock(8'h01, 1'b1, 24'o1257);
      chk(applied, 51'd12);
      slope_en = 1'b0;
      run_lock(8'h0F, 1'b1, 24'o13567);
      run_lock(8'hC0, 1'b0, 24'o467);
      run_lock(8'h20, 1'b0, 24'o37);
      // No lock: wide acquisition must hold, with phase slope cap left normal
      lock_det = 1'b0;
      wsel = 3'h5;
      run_lock(8'h08, 1'b1, 24'o56);
      chk({rbw, rpsl}, {16'h0100, 32'h00000010});
      final_report;
   end
   // Watchdog well beyond the expected few thousand cycles
   initial
   begin
      #100000;
      error_cnt = error_cnt + 1;
      final_report;
   end
endmodule // fsop_top_bench
